// ===== hw/thi_handler.sv
// Transport indication handler: validates and dispatches received frames,
// checks read/write requests against the pending command table, maps data
// completions and runs quiesce. Inputs are synchronous to core_clk_in;
// each requester holds its valid until it sees ready_out high with it.
//
// Overview of operation
// - Validate every arrived frame before acting on its contents
// - Dispatch valid frames by message code to the matching handler
// - Transfer offset is carried as four bytes, relative to buffer base
// - Transfer count is four bytes, covering only the current request
// - Message length is one byte counting the frame data portion
// - Initiator channel is two bytes; the handler does not place it into the data addresses
// - Null command count or buffer address in table entry fails request
// - Offset plus count above command count fails request
// - Passing read returns data-in address, starts at address plus offset
// - Passing write returns data-out address, starts at address plus offset
// - Optional start and threshold counts let the transport throttle reads
// - Read-data-completed becomes data-sent confirmation with tag, source, lun
// - Write-data-completed becomes data-out-received confirmation
// - Quiesce issues abort-task-set for every supported logical unit
// - Quiesce fails if any abort reported failure, else succeeds
`timescale 1ns/1ns
`include "thi_params.svh"

module thi_handler #(
    parameter int NUM_LUN   = `THI_NUM_LUN,
    parameter int TBL_DEPTH = `THI_TBL_DEPTH
) (
    input  wire logic                   core_clk_in,
    input  wire logic                   rst_n_in,
    output logic                        ready_out,
    input  wire logic                   msg_valid_in,
    input  wire thi_pkg::thi_msg_t      msg_in,
    output logic                        validate_req_out,
    output thi_pkg::thi_msg_t           validate_msg_out,
    input  wire logic                   validate_done_in,
    input  wire logic                   validate_ok_in,
    output logic                        disp_valid_out,
    output thi_pkg::thi_kind_t          disp_kind_out,
    input  wire logic                   read_ind_in,
    input  wire logic                   write_ind_in,
    input  wire thi_pkg::thi_xreq_t     xreq_in,
    input  wire logic                   throttle_en_in,
    input  wire logic [`THI_CNT_W-1:0]  start_count_in,
    input  wire logic [`THI_CNT_W-1:0]  thresh_count_in,
    output logic                        xfer_valid_out,
    output thi_pkg::thi_xfer_t          xfer_out,
    input  wire logic                   tbl_wr_in,
    input  wire logic [`THI_TAG_W-1:0]  tbl_tag_in,
    input  wire thi_pkg::thi_entry_t    tbl_entry_in,
    input  wire logic                   read_done_in,
    input  wire logic                   write_done_in,
    input  wire thi_pkg::thi_conf_t     done_conf_in,
    output logic                        data_sent_out,
    output logic                        data_out_rcvd_out,
    output thi_pkg::thi_conf_t          conf_out,
    input  wire logic                   quiesce_in,
    output logic                        abort_set_req_out,
    output logic [`THI_LUN_W-1:0]       abort_lun_out,
    input  wire logic                   abort_set_done_in,
    input  wire logic                   abort_set_fail_in,
    output logic                        ret_valid_out,
    output logic [`THI_CODE_W-1:0]      ret_code_out
);

    localparam int IDX_W = (TBL_DEPTH > 1) ? $clog2(TBL_DEPTH) : 1;
    localparam logic [`THI_LUN_W-1:0] LAST_LUN = `THI_LUN_W'(NUM_LUN - 1);

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_VALID  = 4'b0010,
        ST_LOOKUP = 4'b0100,
        ST_QWAIT  = 4'b1000
    } thi_state_t;

    // Pending command table, one entry per tag below TBL_DEPTH
    thi_pkg::thi_entry_t pending_command_table [TBL_DEPTH];

    genvar gi;
    generate
        for (gi = 0; gi < TBL_DEPTH; gi++) begin : g_tbl
            always_ff @(posedge core_clk_in) begin
                if (!rst_n_in) begin
                    pending_command_table[gi] <= '0;
                end else if (tbl_wr_in && tbl_tag_in == `THI_TAG_W'(gi)) begin
                    pending_command_table[gi] <= tbl_entry_in;
                end
            end
        end
    endgenerate

    thi_state_t          state_r,    state_nxt;
    logic                ready_r,    ready_nxt;
    logic                vreq_r,     vreq_nxt;
    thi_pkg::thi_msg_t   msg_r,      msg_nxt;
    logic                disp_r,     disp_nxt;
    thi_pkg::thi_kind_t  kind_r,     kind_nxt;
    thi_pkg::thi_xreq_t  xreq_r,     xreq_nxt;
    logic                is_wr_r,    is_wr_nxt;
    logic                xv_r,       xv_nxt;
    thi_pkg::thi_xfer_t  xfer_r,     xfer_nxt;
    logic                sent_r,     sent_nxt;
    logic                orcv_r,     orcv_nxt;
    thi_pkg::thi_conf_t  conf_r,     conf_nxt;
    logic                abrq_r,     abrq_nxt;
    logic [`THI_LUN_W-1:0] lun_r,    lun_nxt;
    logic                qfail_r,    qfail_nxt;
    logic                rv_r,       rv_nxt;
    logic [`THI_CODE_W-1:0] rc_r,    rc_nxt;

    thi_pkg::thi_entry_t ent;
    logic [`THI_CNT_W:0] end_pos;
    logic                tag_in_range;

    always_comb begin
        ent          = pending_command_table[xreq_r.tag[IDX_W-1:0]];
        end_pos      = {1'b0, xreq_r.offset} + {1'b0, xreq_r.count};
        tag_in_range = (32'(xreq_r.tag) < 32'(TBL_DEPTH));
        state_nxt = state_r;
        ready_nxt = 1'b0;
        vreq_nxt  = 1'b0;
        msg_nxt   = msg_r;
        disp_nxt  = 1'b0;
        kind_nxt  = kind_r;
        xreq_nxt  = xreq_r;
        is_wr_nxt = is_wr_r;
        xv_nxt    = 1'b0;
        xfer_nxt  = xfer_r;
        sent_nxt  = 1'b0;
        orcv_nxt  = 1'b0;
        conf_nxt  = conf_r;
        abrq_nxt  = 1'b0;
        lun_nxt   = lun_r;
        qfail_nxt = qfail_r;
        rv_nxt    = 1'b0;
        rc_nxt    = rc_r;
        case (state_r)
            ST_IDLE: begin
                ready_nxt = 1'b1;
                if (ready_r) begin
                    // Fixed priority, one accepted at a time
                    if (quiesce_in) begin
                        ready_nxt = 1'b0;
                        lun_nxt   = '0;
                        qfail_nxt = 1'b0;
                        abrq_nxt  = 1'b1;
                        state_nxt = ST_QWAIT;
                    end else if (msg_valid_in) begin
                        ready_nxt = 1'b0;
                        msg_nxt   = msg_in;
                        vreq_nxt  = 1'b1;
                        state_nxt = ST_VALID;
                    end else if (read_ind_in || write_ind_in) begin
                        ready_nxt = 1'b0;
                        xreq_nxt  = xreq_in;
                        is_wr_nxt = !read_ind_in;
                        state_nxt = ST_LOOKUP;
                    end else if (read_done_in) begin
                        ready_nxt = 1'b0;
                        sent_nxt  = 1'b1;
                        conf_nxt  = done_conf_in;
                    end else if (write_done_in) begin
                        ready_nxt = 1'b0;
                        orcv_nxt  = 1'b1;
                        conf_nxt  = done_conf_in;
                    end
                end
            end
            ST_VALID: begin
                if (validate_done_in) begin
                    state_nxt = ST_IDLE;
                    if (validate_ok_in) begin
                        disp_nxt = 1'b1;
                        case (msg_r.msg_code)
                            `THI_MC_COMMAND:    kind_nxt = thi_pkg::KIND_COMMAND;
                            `THI_MC_STATUS:     kind_nxt = thi_pkg::KIND_STATUS;
                            `THI_MC_ABORT_TASK: kind_nxt = thi_pkg::KIND_ABORT_TASK;
                            `THI_MC_ABORT_SET:  kind_nxt = thi_pkg::KIND_ABORT_SET;
                            `THI_MC_CLEAR_ACA:  kind_nxt = thi_pkg::KIND_CLEAR_ACA;
                            `THI_MC_CLEAR_Q:    kind_nxt = thi_pkg::KIND_CLEAR_Q;
                            `THI_MC_TGT_RESET:  kind_nxt = thi_pkg::KIND_TGT_RESET;
                            `THI_MC_RESPONSE:   kind_nxt = thi_pkg::KIND_RESPONSE;
                            default:            kind_nxt = thi_pkg::KIND_UNKNOWN;
                        endcase
                    end
                end
            end
            ST_LOOKUP: begin
                state_nxt = ST_IDLE;
                rv_nxt    = 1'b1;
                xfer_nxt.buf_addr = is_wr_r ? ent.out_addr : ent.in_addr;
                if (!tag_in_range || ent.cmd_count == `THI_ZERO_CNT
                        || xfer_nxt.buf_addr == `THI_ZERO_ADDR) begin
                    rc_nxt = `THI_RC_FAILED;
                end else if (end_pos > {1'b0, ent.cmd_count}) begin
                    rc_nxt = `THI_RC_FAILED;
                end else begin
                    rc_nxt = `THI_RC_SUCCESS;
                    xv_nxt = 1'b1;
                    xfer_nxt.start_addr = xfer_nxt.buf_addr + xreq_r.offset;
                    xfer_nxt.length     = xreq_r.count;
                    if (throttle_en_in && !is_wr_r) begin
                        xfer_nxt.start_cnt  = start_count_in;
                        xfer_nxt.thresh_cnt = thresh_count_in;
                    end else begin
                        xfer_nxt.start_cnt  = xreq_r.count;
                        xfer_nxt.thresh_cnt = `THI_ZERO_CNT;
                    end
                end
            end
            ST_QWAIT: begin
                if (abort_set_done_in) begin
                    qfail_nxt = qfail_r || abort_set_fail_in;
                    if (lun_r == LAST_LUN) begin
                        state_nxt = ST_IDLE;
                        rv_nxt    = 1'b1;
                        rc_nxt    = (qfail_r || abort_set_fail_in)
                                    ? `THI_RC_FAILED : `THI_RC_SUCCESS;
                    end else begin
                        lun_nxt  = lun_r + `THI_LUN_W'(1);
                        abrq_nxt = 1'b1;
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            state_r <= ST_IDLE;
            ready_r <= 1'b0;
            vreq_r  <= 1'b0;
            msg_r   <= '0;
            disp_r  <= 1'b0;
            kind_r  <= thi_pkg::KIND_NONE;
            xreq_r  <= '0;
            is_wr_r <= 1'b0;
            xv_r    <= 1'b0;
            xfer_r  <= '0;
            sent_r  <= 1'b0;
            orcv_r  <= 1'b0;
            conf_r  <= '0;
            abrq_r  <= 1'b0;
            lun_r   <= '0;
            qfail_r <= 1'b0;
            rv_r    <= 1'b0;
            rc_r    <= `THI_RC_SUCCESS;
        end else begin
            state_r <= state_nxt;
            ready_r <= ready_nxt;
            vreq_r  <= vreq_nxt;
            msg_r   <= msg_nxt;
            disp_r  <= disp_nxt;
            kind_r  <= kind_nxt;
            xreq_r  <= xreq_nxt;
            is_wr_r <= is_wr_nxt;
            xv_r    <= xv_nxt;
            xfer_r  <= xfer_nxt;
            sent_r  <= sent_nxt;
            orcv_r  <= orcv_nxt;
            conf_r  <= conf_nxt;
            abrq_r  <= abrq_nxt;
            lun_r   <= lun_nxt;
            qfail_r <= qfail_nxt;
            rv_r    <= rv_nxt;
            rc_r    <= rc_nxt;
        end
    end

    assign ready_out         = ready_r;
    assign validate_req_out  = vreq_r;
    assign validate_msg_out  = msg_r;
    assign disp_valid_out    = disp_r;
    assign disp_kind_out     = kind_r;
    assign xfer_valid_out    = xv_r;
    assign xfer_out          = xfer_r;
    assign data_sent_out     = sent_r;
    assign data_out_rcvd_out = orcv_r;
    assign conf_out          = conf_r;
    assign abort_set_req_out = abrq_r;
    assign abort_lun_out     = lun_r;
    assign ret_valid_out     = rv_r;
    assign ret_code_out      = rc_r;

endmodule : thi_handler

// ===== hw/thi_params.svh
// Constants for the transport indication handler: codes, widths, reset values.
// Included by the package and the handler; holds definitions only.
`ifndef THI_PARAMS_SVH
`define THI_PARAMS_SVH

`define THI_ADDR_W        32
`define THI_OFFS_W        32
`define THI_CNT_W         32
`define THI_LEN_W         8
`define THI_CHAN_W        16
`define THI_TAG_W         16
`define THI_UID_W         16
`define THI_LUN_W         8
`define THI_CODE_W        8

// Return codes
`define THI_RC_SUCCESS    8'h00
`define THI_RC_FAILED     8'h01

// Message codes of the protocol frames
`define THI_MC_COMMAND    8'h01
`define THI_MC_STATUS     8'h02
`define THI_MC_RESPONSE   8'h03
`define THI_MC_ABORT_TASK 8'h30
`define THI_MC_ABORT_SET  8'h31
`define THI_MC_CLEAR_Q    8'h32
`define THI_MC_TGT_RESET  8'h33
`define THI_MC_CLEAR_ACA  8'h34

// Defaults and reset values
`define THI_NUM_LUN       8
`define THI_TBL_DEPTH     16
`define THI_ZERO_ADDR     32'h0000_0000
`define THI_ZERO_CNT      32'h0000_0000

`endif

// ===== hw/thi_pkg.sv
// Types for the transport indication handler.
// Widths come from thi_params.svh.
`include "thi_params.svh"

package thi_pkg;

    typedef enum logic [8:0] {
        KIND_NONE       = 9'h000,
        KIND_COMMAND    = 9'h001,
        KIND_STATUS     = 9'h002,
        KIND_ABORT_TASK = 9'h004,
        KIND_ABORT_SET  = 9'h008,
        KIND_CLEAR_ACA  = 9'h010,
        KIND_CLEAR_Q    = 9'h020,
        KIND_TGT_RESET  = 9'h040,
        KIND_RESPONSE   = 9'h080,
        KIND_UNKNOWN    = 9'h100
    } thi_kind_t;

    typedef struct packed {
        logic [`THI_CODE_W-1:0] control;
        logic [`THI_ADDR_W-1:0] buf_addr;
        logic [`THI_LEN_W-1:0]  length;
        logic [`THI_CODE_W-1:0] msg_code;
    } thi_msg_t;

    typedef struct packed {
        logic [`THI_TAG_W-1:0]  tag;
        logic [`THI_OFFS_W-1:0] offset;
        logic [`THI_CNT_W-1:0]  count;
    } thi_xreq_t;

    typedef struct packed {
        logic [`THI_CNT_W-1:0]  cmd_count;
        logic [`THI_ADDR_W-1:0] in_addr;
        logic [`THI_ADDR_W-1:0] out_addr;
    } thi_entry_t;

    typedef struct packed {
        logic [`THI_ADDR_W-1:0] buf_addr;
        logic [`THI_ADDR_W-1:0] start_addr;
        logic [`THI_CNT_W-1:0]  length;
        logic [`THI_CNT_W-1:0]  start_cnt;
        logic [`THI_CNT_W-1:0]  thresh_cnt;
    } thi_xfer_t;

    typedef struct packed {
        logic [`THI_TAG_W-1:0] tag;
        logic [`THI_UID_W-1:0] uid;
        logic [`THI_LUN_W-1:0] lun;
    } thi_conf_t;

endpackage : thi_pkg

// ===== tb/thi_handler_props.sv
// Port-level timing checks for thi_handler.
// Bound to every thi_handler instance; sees its ports only.
`timescale 1ns/1ns
`include "thi_params.svh"

module thi_handler_props #(
    parameter int NUM_LUN = 8
) (
    input wire logic       core_clk_in,
    input wire logic       rst_n_in,
    input wire logic       ready_out,
    input wire logic       msg_valid_in,
    input wire logic       validate_req_out,
    input wire logic       validate_done_in,
    input wire logic       validate_ok_in,
    input wire logic       disp_valid_out,
    input wire logic       read_ind_in,
    input wire logic       write_ind_in,
    input wire logic       xfer_valid_out,
    input wire logic       read_done_in,
    input wire logic       write_done_in,
    input wire logic       data_sent_out,
    input wire logic       data_out_rcvd_out,
    input wire logic       quiesce_in,
    input wire logic       abort_set_req_out,
    input wire logic [7:0] abort_lun_out,
    input wire logic       abort_set_done_in,
    input wire logic       ret_valid_out,
    input wire logic [7:0] ret_code_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    // Accepted request of each kind, by priority
    wire logic q_take  = ready_out && quiesce_in;
    wire logic m_take  = ready_out && !quiesce_in && msg_valid_in;
    wire logic lo_free = ready_out && !quiesce_in && !msg_valid_in;
    wire logic rw_take = lo_free && (read_ind_in || write_ind_in);
    wire logic dn_free = lo_free && !read_ind_in && !write_ind_in;
    wire logic rd_take = dn_free && read_done_in;
    wire logic wd_take = dn_free && !read_done_in && write_done_in;

    sequence s_first_abort;
        abort_set_req_out && abort_lun_out == 8'h00;
    endsequence
    sequence s_next_abort;
        abort_set_req_out && abort_lun_out == $past(abort_lun_out) + 8'h01;
    endsequence

    property p_val_req;  m_take |=> validate_req_out; endproperty
    property p_disp;  disp_valid_out |-> $past(validate_done_in && validate_ok_in); endproperty
    property p_rw;  rw_take |=> !ready_out ##1 ret_valid_out; endproperty
    property p_xfer;
        xfer_valid_out |-> ret_valid_out && ret_code_out == `THI_RC_SUCCESS;
    endproperty
    property p_sent;  rd_take |=> data_sent_out && !data_out_rcvd_out; endproperty
    property p_rcvd;  wd_take |=> data_out_rcvd_out && !data_sent_out; endproperty
    property p_q_start;  q_take |=> s_first_abort; endproperty
    property p_q_step;
        abort_set_done_in && abort_lun_out < NUM_LUN - 1 |=> s_next_abort;
    endproperty
    property p_q_end;
        abort_set_done_in && abort_lun_out == NUM_LUN - 1 |=> ret_valid_out;
    endproperty
    property p_one;  ret_valid_out |-> !ready_out; endproperty

    a_val_req: assert property (p_val_req) else $error("no validation request");
    a_disp: assert property (p_disp) else $error("dispatch without valid frame");
    a_rw: assert property (p_rw) else $error("lookup answer late");
    a_xfer: assert property (p_xfer) else $error("transfer on failed code");
    a_sent: assert property (p_sent) else $error("no data sent confirm");
    a_rcvd: assert property (p_rcvd) else $error("no data out confirm");
    a_q_start: assert property (p_q_start) else $error("first abort wrong");
    a_q_step: assert property (p_q_step) else $error("abort unit skipped");
    a_q_end: assert property (p_q_end) else $error("quiesce code late");
    a_one: assert property (p_one) else $error("taking while answering");
endmodule : thi_handler_props

bind thi_handler thi_handler_props #(.NUM_LUN(NUM_LUN)) u_props (.*);

// ===== tb/thi_xport_model.sv
// Far side: frame validator and abort responder with set delay.
// Answers only after a request; when idle the abort fail line toggles and the ok line holds the inverse of ok_sel_in.
`timescale 1ns/1ns

module thi_xport_model (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       validate_req_in,
    input  wire logic       abort_req_in,
    input  wire logic [7:0] abort_lun_in,
    input  wire logic       ok_sel_in,
    input  wire logic [7:0] fail_lun_in,
    input  wire logic [3:0] delay_in,
    output logic            validate_done_out,
    output logic            validate_ok_out,
    output logic            abort_done_out,
    output logic            abort_fail_out,
    output logic [7:0]      lun_seen_out
);
    logic [3:0] vcnt_r, acnt_r;
    logic [7:0] lun_r;

    always @(posedge clk_in) begin
        validate_done_out <= 1'b0;
        abort_done_out <= 1'b0;
        validate_ok_out <= ~ok_sel_in;
        abort_fail_out <= ~abort_fail_out;
        if (!rst_n_in) begin
            vcnt_r <= 4'h0;
            acnt_r <= 4'h0;
            lun_seen_out <= 8'h00;
        end else begin
            if (validate_req_in) begin
                vcnt_r <= delay_in;
            end else if (vcnt_r != 4'h0) begin
                vcnt_r <= vcnt_r - 4'h1;
                validate_done_out <= (vcnt_r == 4'h1);
                validate_ok_out <= (vcnt_r == 4'h1) ? ok_sel_in : ~ok_sel_in;
            end
            if (abort_req_in) begin
                acnt_r <= delay_in;
                lun_r <= abort_lun_in;
                lun_seen_out <= lun_seen_out | (8'h01 << abort_lun_in);
            end else if (acnt_r != 4'h0) begin
                acnt_r <= acnt_r - 4'h1;
                abort_done_out <= (acnt_r == 4'h1);
                abort_fail_out <= (lun_r == fail_lun_in);
            end
        end
    end
endmodule : thi_xport_model

// ===== tb/thi_handler_tb.sv
// Self-checking bench for thi_handler with the far-side model.
// Three logical units; table depth left at its default.
`timescale 1ns/1ns
`include "thi_params.svh"

module thi_handler_tb;
    logic core_clk_in, rst_n_in, msg_valid_in, read_ind_in, write_ind_in, throttle_en_in;
    logic tbl_wr_in, read_done_in, write_done_in, quiesce_in, ok_sel;
    logic ready_out, validate_req_out, validate_done_in, validate_ok_in, disp_valid_out;
    logic xfer_valid_out, data_sent_out, data_out_rcvd_out, abort_set_req_out;
    logic abort_set_done_in, abort_set_fail_in, ret_valid_out;
    logic [7:0]          abort_lun_out, ret_code_out, fail_lun, lun_seen;
    logic [31:0]         start_count_in, thresh_count_in;
    logic [15:0]         tbl_tag_in;
    logic [3:0]          dly;
    thi_pkg::thi_msg_t   msg_in, validate_msg_out;
    thi_pkg::thi_kind_t  disp_kind_out;
    thi_pkg::thi_xreq_t  xreq_in;
    thi_pkg::thi_xfer_t  xfer_out;
    thi_pkg::thi_entry_t tbl_entry_in;
    thi_pkg::thi_conf_t  done_conf_in, conf_out;
    int                  miscompares, check_count, i;
    logic [7:0] codes [9] = '{`THI_MC_COMMAND, `THI_MC_STATUS, `THI_MC_RESPONSE,
        `THI_MC_ABORT_TASK, `THI_MC_ABORT_SET, `THI_MC_CLEAR_Q, `THI_MC_TGT_RESET,
        `THI_MC_CLEAR_ACA, 8'h7F};
    thi_pkg::thi_kind_t kinds [9] = '{thi_pkg::KIND_COMMAND, thi_pkg::KIND_STATUS,
        thi_pkg::KIND_RESPONSE, thi_pkg::KIND_ABORT_TASK, thi_pkg::KIND_ABORT_SET,
        thi_pkg::KIND_CLEAR_Q, thi_pkg::KIND_TGT_RESET, thi_pkg::KIND_CLEAR_ACA,
        thi_pkg::KIND_UNKNOWN};

    thi_handler #(.NUM_LUN(3)) u_dut (.*);

    thi_xport_model u_far (.clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .validate_req_in(validate_req_out), .abort_req_in(abort_set_req_out),
        .abort_lun_in(abort_lun_out), .ok_sel_in(ok_sel), .fail_lun_in(fail_lun),
        .delay_in(dly), .validate_done_out(validate_done_in),
        .validate_ok_out(validate_ok_in), .abort_done_out(abort_set_done_in),
        .abort_fail_out(abort_set_fail_in), .lun_seen_out(lun_seen));

    initial begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end

    task automatic stop_test();
        $display("Checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [159:0] got, input logic [159:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk

    task automatic step();
        @(posedge core_clk_in);
        #2;
    endtask : step

    // Hold request until an edge with ready high takes it
    task automatic wait_take();
        for (int n = 0; n < 60 && ready_out !== 1'b1; n++) step();
        chk(ready_out, 1'b1);
        step();
    endtask : wait_take

    task automatic wait_ret();
        for (int n = 0; n < 60 && ret_valid_out !== 1'b1; n++) step();
        chk(ret_valid_out, 1'b1);
    endtask : wait_ret

    task automatic tbl(input logic [15:0] tag, input logic [31:0] c, ia, oa);
        tbl_tag_in = tag;
        tbl_entry_in = {c, ia, oa};
        tbl_wr_in = 1'b1;
        step();
        tbl_wr_in = 1'b0;
        step();
    endtask : tbl

    task automatic rw(input logic rd, input logic [15:0] tag, input logic [31:0] off, cnt,
                      input logic [7:0] code, input logic [31:0] bufa);
        logic [31:0] sc, tc;
        sc = (throttle_en_in && rd) ? start_count_in : cnt;
        tc = (throttle_en_in && rd) ? thresh_count_in : 32'h0000_0000;
        read_ind_in = rd;
        write_ind_in = !rd;
        xreq_in = {tag, off, cnt};
        wait_take();
        read_ind_in = 1'b0;
        write_ind_in = 1'b0;
        wait_ret();
        chk(ret_code_out, code);
        chk(xfer_valid_out, code == `THI_RC_SUCCESS);
        if (code == `THI_RC_SUCCESS)
            chk(xfer_out, {bufa, bufa + off, cnt, sc, tc});
    endtask : rw

    task automatic msg(input logic [7:0] code, input logic ok, input thi_pkg::thi_kind_t k);
        logic got;
        got = 1'b0;
        ok_sel = ok;
        msg_in = {8'h00, 32'h0000_4000, 8'h18, code};
        msg_valid_in = 1'b1;
        wait_take();
        msg_valid_in = 1'b0;
        for (int n = 0; n < 20 && !got; n++) begin
            step();
            got = (disp_valid_out === 1'b1);
            if (got) chk(disp_kind_out, k);
        end
        chk(got, ok);
        chk(validate_msg_out, msg_in);
    endtask : msg

    task automatic done_cf(input logic rd);
        done_conf_in = {16'h0005, 16'h0A0B, 7'h01, rd};
        read_done_in = rd;
        write_done_in = !rd;
        wait_take();
        read_done_in = 1'b0;
        write_done_in = 1'b0;
        chk({data_sent_out, data_out_rcvd_out}, {rd, !rd});
        chk(conf_out, done_conf_in);
    endtask : done_cf

    task automatic quiesce(input logic [7:0] fl, input logic [7:0] code);
        fail_lun = fl;
        quiesce_in = 1'b1;
        wait_take();
        quiesce_in = 1'b0;
        wait_ret();
        chk(ret_code_out, code);
        chk(lun_seen, 8'h07);
    endtask : quiesce

    initial begin
        {rst_n_in, msg_valid_in, read_ind_in, write_ind_in, throttle_en_in} = 5'h00;
        {tbl_wr_in, read_done_in, write_done_in, quiesce_in, ok_sel} = 5'h00;
        {start_count_in, thresh_count_in, tbl_tag_in, fail_lun} = 88'h0;
        {msg_in, xreq_in, tbl_entry_in, done_conf_in} = '0;
        dly = 4'h5;
        miscompares = 0;
        check_count = 0;
        repeat (16) @(posedge core_clk_in);
        #2 rst_n_in = 1'b1;
        tbl(16'h0001, 32'h0000_0100, 32'h0000_1000, 32'h0000_2000);
        tbl(16'h0003, 32'h0000_0000, 32'h0000_3000, 32'h0000_4000);
        tbl(16'h0004, 32'h0000_0100, 32'h0000_5000, 32'h0000_0000);
        throttle_en_in = 1'b1;
        start_count_in = 32'h0000_0008;
        thresh_count_in = 32'h0000_0004;
        rw(1'b1, 16'h0001, 32'h0000_0010, 32'h0000_0020, `THI_RC_SUCCESS, 32'h0000_1000);
        rw(1'b0, 16'h0001, 32'h0000_00F0, 32'h0000_0010, `THI_RC_SUCCESS, 32'h0000_2000);
        throttle_en_in = 1'b0;
        rw(1'b1, 16'h0001, 32'h0000_00F1, 32'h0000_0010, `THI_RC_FAILED, 32'h0);
        rw(1'b0, 16'h0001, 32'hFFFF_FFFF, 32'h0000_0002, `THI_RC_FAILED, 32'h0);
        rw(1'b1, 16'h0002, 32'h0000_0000, 32'h0000_0004, `THI_RC_FAILED, 32'h0);
        rw(1'b1, 16'h0003, 32'h0000_0000, 32'h0000_0004, `THI_RC_FAILED, 32'h0);
        rw(1'b0, 16'h0004, 32'h0000_0000, 32'h0000_0004, `THI_RC_FAILED, 32'h0);
        $display("Test lookup done");
        for (i = 0; i < 9; i++) msg(codes[i], 1'b1, kinds[i]);
        dly = 4'h1;
        msg(`THI_MC_COMMAND, 1'b0, thi_pkg::KIND_NONE);
        msg(`THI_MC_STATUS, 1'b1, thi_pkg::KIND_STATUS);
        $display("Test dispatch done");
        done_cf(1'b1);
        done_cf(1'b0);
        $display("Test confirm done");
        quiesce(8'hFF, `THI_RC_SUCCESS);
        dly = 4'h4;
        // Mid-run reset clears the far side's record of aborted units
        rst_n_in = 1'b0;
        repeat (2) step();
        chk({ready_out, ret_valid_out, ret_code_out}, 10'h000);
        rst_n_in = 1'b1;
        quiesce(8'h00, `THI_RC_FAILED);
        $display("Test quiesce done");
        stop_test();
    end

    initial begin
        #100000;
        miscompares++;
        stop_test();
    end
endmodule : thi_handler_tb
